/* File: inc/nbtm_map.svh */
// Register map, field positions, reset values and timing figures
// Assumes inclusion by the package user; definitions only
`ifndef NBTM_MAP_SVH
`define NBTM_MAP_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define NBTM_CLK_HZ 10000000
`define NBTM_STEP200_PS 16'h1388
`define NBTM_STEP400_PS 16'h09c4
`define NBTM_BUSY_MIN_NS 100
`define NBTM_BUSY_MAX_NS 250000000
`define NBTM_NCH 24
// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define NBTM_OFS_CTRL 8'h00
`define NBTM_OFS_LSB 8'h04
`define NBTM_OFS_MAP0 8'h08
`define NBTM_OFS_DLY 8'h18
`define NBTM_OFS_CMD 8'h1c
`define NBTM_OFS_ROW 8'h20
`define NBTM_OFS_ROWM 8'h24
`define NBTM_OFS_COL 8'h28
`define NBTM_OFS_DATA 8'h2c
`define NBTM_OFS_BLIST0 8'h30
`define NBTM_OFS_BCFG0 8'h40
`define NBTM_OFS_BCMD0 8'h58
`define NBTM_OFS_STAT 8'h70
`define NBTM_OFS_LAST 8'h74
// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define NBTM_CTRL_EN 0
`define NBTM_CTRL_X16 1
`define NBTM_CTRL_QUICK 2
`define NBTM_CTRL_DDR 3
`define NBTM_CTRL_START 4
`define NBTM_CTRL_R400 5
`define NBTM_CTRL_BCMD 6
`define NBTM_CTRL_BCHK 7
`define NBTM_CTRL_COL 8
`define NBTM_CTRL_ROW4 9
`define NBTM_CTRL_CLR 10
`define NBTM_CTRL_RST 10'h144
`define NBTM_BLIST_RST0 32'hffffff70
`define NBTM_BLIST_RST1 32'hff7bff78
`define NBTM_BCFG_USED 22
`define NBTM_BCFG_DC 26
`define NBTM_PIN_RST 7'h3c
`endif

/* File: inc/nbtm_pkg.sv */
// Types shared by the trigger matcher and its busy timers
// Assumes nothing beyond the map header
package nbtm_pkg;
	typedef logic [31:0] nbtm_word_type;
	typedef logic [4:0] nbtm_chan_type;
	typedef logic [21:0] nbtm_thr_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_CHK = 3'h3,
		ST_DATA = 3'h2,
		ST_HIT = 3'h6
	} nbtm_state_type;
endpackage

/* File: verification/nbtm_flash_model.sv */
// Flash and host model: command, address and data write cycles, busy line
// Assumes the caller runs one task at a time, clocked by pclk
`timescale 1ns/1ps

module nbtm_flash_model (
	input wire logic pclk,
	output logic [23:0] chan_in,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic rdstb_n,
	output logic ce_n,
	output logic rb,
	output logic dqs
);
	logic [7:0] io;
	// Released lines show the inverse of their last byte
	assign chan_in = {~io, ~io, io};
	initial begin
		io = 8'h00;
		cle = 1'b0;
		ale = 1'b0;
		we_n = 1'b1;
		rdstb_n = 1'b1;
		ce_n = 1'b1;
		rb = 1'b1;
		dqs = 1'b0;
	end
	// One write strobe cycle, held long enough for the input sync
	task wr(input logic c, input logic a, input logic [7:0] b);
		@(posedge pclk);
		ce_n <= 1'b0;
		cle <= c;
		ale <= a;
		io <= b;
		we_n <= 1'b0;
		repeat (3) @(posedge pclk);
		we_n <= 1'b1;
		repeat (3) @(posedge pclk);
		cle <= 1'b0;
		ale <= 1'b0;
		io <= ~b;
	endtask
	task busy(input logic v);
		@(posedge pclk);
		rb <= v;
	endtask
	// Read cycle: data valid for one cycle, two cycles after the strobe falls
	task rd(input logic [7:0] b);
		@(posedge pclk);
		rdstb_n <= 1'b0;
		io <= ~b;
		repeat (2) @(posedge pclk);
		io <= b;
		@(posedge pclk);
		io <= ~b;
		@(posedge pclk);
		rdstb_n <= 1'b1;
	endtask
endmodule

/* File: verification/tb.sv */
// Bench for the trigger matcher: APB tasks, flash model, verdict
// Assumes the package, map header and flash model are compiled first
`timescale 1ns/1ps

module tb;
	import nbtm_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	nbtm_word_type pwdata = 32'h0;
	nbtm_word_type prdata, r;
	logic pready, pslverr, e, trig_out, cle, ale, we_n, rdstb_n, ce_n, rb, dqs;
	logic [23:0] chan_in;
	int fails = 0;
	int samples_checked = 0;
	always #50 pclk = ~pclk;
	nbtm_matcher #(.BUSY_MAX_CYC(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
		.command_latch_strobe(cle), .address_latch_strobe(ale), .write_strobe_n(we_n),
		.read_strobe_n(rdstb_n), .chip_enable_n(ce_n), .ready_busy_line(rb),
		.data_strobe_line(dqs), .trig_out(trig_out));
	nbtm_flash_model fm (.pclk(pclk), .chan_in(chan_in), .cle(cle), .ale(ale),
		.we_n(we_n), .rdstb_n(rdstb_n), .ce_n(ce_n), .rb(rb), .dqs(dqs));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task apb(input logic w, input logic [7:0] a, input nbtm_word_type d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input string s, input nbtm_word_type x, input nbtm_word_type g);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("BAD %s exp %h got %h", s, x, g);
		end
	endtask
	task rc(input logic [7:0] a, input nbtm_word_type x);
		apb(1'b0, a, 32'h0);
		chk("prdata", x, r);
	endtask
	task tc(input logic x);
		repeat (8) @(negedge pclk);
		chk("trig_out", 32'(x), 32'(trig_out));
	endtask
	task seq(input logic [7:0] c, input logic [39:0] ab, input int n, input logic [7:0] d);
		fm.wr(1'b1, 1'b0, c);
		for (int i = 0; i < n; i++) begin
			fm.wr(1'b0, 1'b1, ab[8*i+:8]);
		end
		fm.wr(1'b0, 1'b0, d);
	endtask
	task end_sim;
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc(8'h00, 32'h00000144);
		rc(8'h30, 32'hffffff70);
		rc(8'h34, 32'hff7bff78);
		rc(8'h18, 32'h13880000);
		apb(1'b1, 8'h00, 32'h00000164);
		rc(8'h18, 32'h09c40000);
		apb(1'b0, 8'h80, 32'h0);
		chk("pslverr", 32'h1, 32'(e));
		apb(1'b1, 8'h1c, 32'h0000ff80);
		apb(1'b1, 8'h20, 32'h000026b1);
		apb(1'b1, 8'h24, 32'h00ffffff);
		apb(1'b1, 8'h28, 32'hffff0000);
		apb(1'b1, 8'h2c, 32'h00ff007b);
		apb(1'b1, 8'h00, 32'h00000145);
		seq(8'h80, 40'h0026b20000, 5, 8'h7b);
		tc(1'b0);
		seq(8'h80, 40'h0026b10000, 5, 8'h7b);
		tc(1'b1);
		apb(1'b1, 8'h00, 32'h00000545);
		tc(1'b0);
		apb(1'b1, 8'h1c, 32'h0000ff70);
		apb(1'b1, 8'h24, 32'h0);
		apb(1'b1, 8'h2c, 32'h0);
		apb(1'b1, 8'h00, 32'h00000045);
		fm.busy(1'b0);
		seq(8'h70, 40'h0, 3, 8'h55);
		fm.busy(1'b1);
		tc(1'b1);
		apb(1'b1, 8'h00, 32'h00000445);
		apb(1'b1, 8'h40, 32'h00400005);
		apb(1'b1, 8'h58, 32'h00000010);
		apb(1'b1, 8'h00, 32'h000000c5);
		fm.wr(1'b1, 1'b0, 8'h10);
		fm.busy(1'b0);
		repeat (12) @(posedge pclk);
		fm.busy(1'b1);
		tc(1'b1);
		apb(1'b1, 8'h00, 32'h000004c5);
		fm.wr(1'b1, 1'b0, 8'h10);
		fm.busy(1'b0);
		fm.busy(1'b1);
		tc(1'b0);
		apb(1'b1, 8'h18, 32'h00000002);
		fm.rd(8'ha5);
		rc(8'h74, 32'h0000a510);
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		end_sim;
	end
endmodule

/* File: verilog/nbtm_busy_timer.sv */
// One busy-duration check: arm on a listed command, time the busy period
// Assumes command strobe and busy level are already synchronised to pclk
`timescale 1ns/1ps
`include "nbtm_map.svh"

module nbtm_busy_timer #(
	parameter int MAX_CYC = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic cmd_stb,
	input wire logic [7:0] cmd_byte,
	input wire logic busy,
	input wire nbtm_pkg::nbtm_word_type cmds,
	input wire nbtm_pkg::nbtm_word_type cfg,
	output logic fire
);
	import nbtm_pkg::*;
	localparam longint MIN_L = (64'(`NBTM_BUSY_MIN_NS) * 64'(`NBTM_CLK_HZ) + 64'd999999999)
		/ 64'd1000000000;
	localparam nbtm_thr_type MINT = (MIN_L < 1) ? 22'h000001 : nbtm_thr_type'(MIN_L);
	localparam nbtm_thr_type MAXT = nbtm_thr_type'(MAX_CYC);
	logic [3:0] ent_hit;
	nbtm_thr_type thr_eff;
	nbtm_thr_type cnt_reg;
	nbtm_thr_type cnt_next;
	logic armed_reg;
	logic run_reg;
	logic done_reg;
	logic reach;
	// ---------------------------------------------------------------
	// Command association and threshold
	// ---------------------------------------------------------------
	for (genvar e = 0; e < 4; e++) begin : g_ent
		assign ent_hit[e] = cfg[`NBTM_BCFG_USED + e] &
			(cfg[`NBTM_BCFG_DC + e] | (cmds[e * 8 +: 8] == cmd_byte));
	end
	assign thr_eff = (cfg[21:0] < MINT) ? MINT : (cfg[21:0] > MAXT) ? MAXT : cfg[21:0];
	assign cnt_next = (cnt_reg == 22'h3fffff) ? cnt_reg : cnt_reg + 22'h000001;
	assign reach = cnt_next >= thr_eff;
	// ---------------------------------------------------------------
	// Busy measurement
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_reg <= 1'b0;
			run_reg <= 1'b0;
			done_reg <= 1'b0;
			cnt_reg <= 22'h000000;
			fire <= 1'b0;
		end else begin
			fire <= enable & armed_reg & busy & ~done_reg & reach & ~(cmd_stb & |ent_hit);
			if (!enable) begin
				armed_reg <= 1'b0;
				run_reg <= 1'b0;
			end else if (cmd_stb && |ent_hit) begin
				armed_reg <= 1'b1;
				run_reg <= 1'b0;
				done_reg <= 1'b0;
				cnt_reg <= 22'h000000;
			end else if (armed_reg && busy) begin
				run_reg <= 1'b1;
				cnt_reg <= cnt_next;
				done_reg <= done_reg | reach;
			end else if (run_reg) begin
				armed_reg <= 1'b0;
				run_reg <= 1'b0;
			end
		end
	end
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_fire_reach: assert property (@(posedge pclk) disable iff (!presetn)
		fire |-> (cnt_reg >= thr_eff && $past(busy)))
		else $error("busy check fired below threshold");
	chk_thr_range: assert property (@(posedge pclk) disable iff (!presetn)
		thr_eff >= MINT && thr_eff <= MAXT)
		else $error("busy threshold outside its range");
endmodule

/* File: verilog/nbtm_matcher.sv */
// Trigger matcher for a watched NAND flash bus, with APB registers
// Assumes pins arrive asynchronously to pclk; APB master runs on pclk
//
// Functional notes
// - A width setting picks 8 or 16 data lines sampled on every cycle.
// - Quick setup takes data lines from consecutive channels starting at the LSB channel.
// - User setup maps each data line 0 to 15 to any channel on its own.
// - An enabled data strobe gives double-rate capture, else single-rate by default.
// - A startup-mode option picks the double-rate variant for command and address.
// - Read data is sampled a programmed delay after the read strobe or data strobe edge.
// - The delay counts sample periods of 5 ns at 200 MHz or 2.5 ns at 400 MHz.
// - Matching of commands seen while busy is on after reset.
// - Command matching stays active while busy checks run.
// - The busy command list has eight entries preloaded 70h FFh 78h 7Bh, rest don't-care.
// - Six busy thresholds each start on up to four commands.
// - A busy check fires when busy lasts at least its threshold after its command.
// - Each threshold spans 0.1 us to 250 ms.
// - The address has a 3 or 4 byte row and an optional 2 byte column compare.
// - A don't-care digit matches every bus value.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "nbtm_map.svh"

module nbtm_matcher #(
	parameter int BUSY_MAX_CYC = int'((64'(`NBTM_BUSY_MAX_NS) * 64'(`NBTM_CLK_HZ))
		/ 64'd1000000000)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire nbtm_pkg::nbtm_word_type pwdata,
	output nbtm_pkg::nbtm_word_type prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [23:0] chan_in,
	input wire logic command_latch_strobe,
	input wire logic address_latch_strobe,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic chip_enable_n,
	input wire logic ready_busy_line,
	input wire logic data_strobe_line,
	output logic trig_out
);
	import nbtm_pkg::*;
	logic [9:0] ctrl_reg;
	nbtm_chan_type lsb_reg;
	nbtm_chan_type map_reg [16];
	logic [3:0] dly_reg;
	logic [15:0] cmd_reg;
	nbtm_word_type row_reg;
	nbtm_word_type rowm_reg;
	nbtm_word_type col_reg;
	nbtm_word_type dat_reg;
	nbtm_word_type blist_reg [4];
	nbtm_word_type bcfg_reg [6];
	nbtm_word_type bcmd_reg [6];
	logic [5:0] bfl_reg;
	logic [7:0] last_cmd_reg;
	logic [15:0] last_dat_reg;
	nbtm_state_type state_reg;
	nbtm_state_type state_next;
	logic [2:0] aidx_reg;
	logic [15:0] col_acc_reg;
	nbtm_word_type row_acc_reg;
	logic [3:0] dly_cnt_reg;
	logic dly_run_reg;
	logic [4:0] since_reg;
	logic [23:0] ch_m;
	logic [23:0] ch_s;
	logic [6:0] pin_m;
	logic [6:0] pin_s;
	logic [6:0] pin_p;
	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic [7:0] pa;
	logic setup;
	logic wr;
	logic [7:0] map_off;
	logic [7:0] bl_off;
	logic [7:0] bc_off;
	logic [7:0] bm_off;
	logic map_sel;
	logic bl_sel;
	logic bc_sel;
	logic bm_sel;
	nbtm_word_type rd_mux;
	logic rd_err;
	logic clr;
	assign pa = {paddr[7:2], 2'b00};
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & pready;
	assign map_off = pa - `NBTM_OFS_MAP0;
	assign bl_off = pa - `NBTM_OFS_BLIST0;
	assign bc_off = pa - `NBTM_OFS_BCFG0;
	assign bm_off = pa - `NBTM_OFS_BCMD0;
	assign map_sel = map_off < 8'h10;
	assign bl_sel = bl_off < 8'h10;
	assign bc_sel = bc_off < 8'h18;
	assign bm_sel = bm_off < 8'h18;
	assign clr = wr && pa == `NBTM_OFS_CTRL && pwdata[`NBTM_CTRL_CLR];
	always_comb begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		if (map_sel) begin
			for (int k = 0; k < 4; k++) begin
				rd_mux[k * 8 +: 8] = {3'h0, map_reg[{map_off[3:2], 2'b00} + 4'(k)]};
			end
		end else if (bl_sel) begin
			rd_mux = blist_reg[bl_off[3:2]];
		end else if (bc_sel) begin
			rd_mux = bcfg_reg[bc_off[4:2]];
		end else if (bm_sel) begin
			rd_mux = bcmd_reg[bm_off[4:2]];
		end else begin
			case (pa)
				`NBTM_OFS_CTRL: rd_mux = {22'h000000, ctrl_reg};
				`NBTM_OFS_LSB: rd_mux = {27'h0000000, lsb_reg};
				`NBTM_OFS_DLY: rd_mux = {ctrl_reg[`NBTM_CTRL_R400] ? `NBTM_STEP400_PS :
					`NBTM_STEP200_PS, 12'h000, dly_reg};
				`NBTM_OFS_CMD: rd_mux = {16'h0000, cmd_reg};
				`NBTM_OFS_ROW: rd_mux = row_reg;
				`NBTM_OFS_ROWM: rd_mux = rowm_reg;
				`NBTM_OFS_COL: rd_mux = col_reg;
				`NBTM_OFS_DATA: rd_mux = dat_reg;
				`NBTM_OFS_STAT: rd_mux = {21'h000000, state_reg, bfl_reg, ~pin_s[5], trig_out};
				`NBTM_OFS_LAST: rd_mux = {8'h00, last_dat_reg, last_cmd_reg};
				default: rd_err = 1'b1;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & rd_err;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `NBTM_CTRL_RST;
			lsb_reg <= 5'h00;
			dly_reg <= 4'h0;
			cmd_reg <= 16'h0000;
			row_reg <= 32'h00000000;
			rowm_reg <= 32'h00000000;
			col_reg <= 32'h00000000;
			dat_reg <= 32'h00000000;
			for (int k = 0; k < 16; k++) map_reg[k] <= nbtm_chan_type'(k);
			blist_reg[0] <= `NBTM_BLIST_RST0;
			blist_reg[1] <= `NBTM_BLIST_RST1;
			blist_reg[2] <= 32'h00000000;
			blist_reg[3] <= 32'h00000000;
			for (int k = 0; k < 6; k++) bcfg_reg[k] <= 32'h00000000;
			for (int k = 0; k < 6; k++) bcmd_reg[k] <= 32'h00000000;
		end else if (wr) begin
			if (pa == `NBTM_OFS_CTRL) ctrl_reg <= pwdata[9:0];
			if (pa == `NBTM_OFS_LSB) lsb_reg <= pwdata[4:0];
			if (pa == `NBTM_OFS_DLY) dly_reg <= pwdata[3:0];
			if (pa == `NBTM_OFS_CMD) cmd_reg <= pwdata[15:0];
			if (pa == `NBTM_OFS_ROW) row_reg <= pwdata;
			if (pa == `NBTM_OFS_ROWM) rowm_reg <= pwdata;
			if (pa == `NBTM_OFS_COL) col_reg <= pwdata;
			if (pa == `NBTM_OFS_DATA) dat_reg <= pwdata;
			if (map_sel) begin
				for (int k = 0; k < 4; k++) begin
					map_reg[{map_off[3:2], 2'b00} + 4'(k)] <= pwdata[k * 8 +: 5];
				end
			end
			if (bl_sel) blist_reg[bl_off[3:2]] <= pwdata;
			if (bc_sel) bcfg_reg[bc_off[4:2]] <= pwdata;
			if (bm_sel) bcmd_reg[bm_off[4:2]] <= pwdata;
		end
	end
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_m <= 24'h000000;
			ch_s <= 24'h000000;
			pin_m <= `NBTM_PIN_RST;
			pin_s <= `NBTM_PIN_RST;
			pin_p <= `NBTM_PIN_RST;
		end else begin
			ch_m <= chan_in;
			ch_s <= ch_m;
			pin_m <= {data_strobe_line, ready_busy_line, chip_enable_n, read_strobe_n,
				write_strobe_n, address_latch_strobe, command_latch_strobe};
			pin_s <= pin_m;
			pin_p <= pin_s;
		end
	end
	// ---------------------------------------------------------------
	// Data line mapping and cycle classification
	// ---------------------------------------------------------------
	logic [15:0] d_map;
	logic [15:0] d_bus;
	logic [7:0] cmd_byte;
	logic act;
	logic busy;
	logic we_rise;
	logic we_fall;
	logic ca_edge;
	logic cmd_stb;
	logic addr_stb;
	logic wdat_stb;
	logic rd_start;
	logic rd_now;
	logic data_stb;
	logic ctrl_ddr;
	for (genvar g = 0; g < 16; g++) begin : g_map
		logic [5:0] idx;
		assign idx = ctrl_reg[`NBTM_CTRL_QUICK] ? 6'(lsb_reg) + 6'(g) : {1'b0, map_reg[g]};
		assign d_map[g] = (idx < 6'(`NBTM_NCH)) ? ch_s[idx[4:0]] : 1'b0;
	end
	assign d_bus = ctrl_reg[`NBTM_CTRL_X16] ? d_map : {8'h00, d_map[7:0]};
	assign cmd_byte = d_map[7:0];
	assign ctrl_ddr = ctrl_reg[`NBTM_CTRL_DDR];
	assign act = ctrl_reg[`NBTM_CTRL_EN] & ~pin_s[4];
	assign busy = ~pin_s[5];
	assign we_rise = act & ~pin_p[2] & pin_s[2];
	assign we_fall = act & pin_p[2] & ~pin_s[2];
	assign ca_edge = (ctrl_ddr && ctrl_reg[`NBTM_CTRL_START]) ? we_fall : we_rise;
	assign cmd_stb = ca_edge & pin_s[0];
	assign addr_stb = ca_edge & pin_s[1] & ~pin_s[0];
	assign wdat_stb = we_rise & ~pin_s[0] & ~pin_s[1] & ~ctrl_ddr;
	assign rd_start = ctrl_ddr ? act & (pin_s[6] ^ pin_p[6]) : act & pin_p[3] & ~pin_s[3];
	assign rd_now = (rd_start & (dly_reg == 4'h0)) | (dly_run_reg & (dly_cnt_reg == 4'h1));
	assign data_stb = wdat_stb | rd_now;
	// ---------------------------------------------------------------
	// Read sampling delay
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_reg <= 4'h0;
			dly_run_reg <= 1'b0;
			since_reg <= 5'h00;
		end else begin
			since_reg <= rd_start ? 5'h00 : (since_reg == 5'h1f) ? since_reg : since_reg + 5'h01;
			if (rd_start) begin
				dly_cnt_reg <= dly_reg;
				dly_run_reg <= dly_reg != 4'h0;
			end else if (dly_run_reg) begin
				dly_cnt_reg <= dly_cnt_reg - 4'h1;
				dly_run_reg <= dly_cnt_reg != 4'h1;
			end
		end
	end
	// ---------------------------------------------------------------
	// Matching
	// ---------------------------------------------------------------
	logic [7:0] bl_hit;
	logic busy_ok;
	logic cmd_ok;
	logic cmd_hit;
	logic cmd_go;
	logic [2:0] addr_total;
	logic [2:0] ncol;
	logic [2:0] ridx;
	nbtm_word_type row_sel;
	logic row_hit;
	logic col_hit;
	logic data_hit;
	logic [5:0] fire;
	for (genvar b = 0; b < 8; b++) begin : g_bl
		assign bl_hit[b] = ((cmd_byte ^ blist_reg[b / 2][(b % 2) * 16 +: 8]) &
			blist_reg[b / 2][(b % 2) * 16 + 8 +: 8]) == 8'h00;
	end
	assign busy_ok = ctrl_reg[`NBTM_CTRL_BCMD] & |bl_hit;
	assign cmd_ok = ~busy | busy_ok;
	assign cmd_hit = ((cmd_byte ^ cmd_reg[7:0]) & cmd_reg[15:8]) == 8'h00;
	assign cmd_go = cmd_stb & cmd_ok & cmd_hit;
	assign ncol = ctrl_reg[`NBTM_CTRL_COL] ? 3'h2 : 3'h0;
	assign addr_total = (ctrl_reg[`NBTM_CTRL_ROW4] ? 3'h4 : 3'h3) + ncol;
	assign ridx = aidx_reg - ncol;
	assign row_sel = ctrl_reg[`NBTM_CTRL_ROW4] ? 32'hffffffff : 32'h00ffffff;
	assign row_hit = ((row_acc_reg ^ row_reg) & rowm_reg & row_sel) == 32'h00000000;
	assign col_hit = ~ctrl_reg[`NBTM_CTRL_COL] |
		(((col_acc_reg ^ col_reg[15:0]) & col_reg[31:16]) == 16'h0000);
	assign data_hit = ((d_bus ^ dat_reg[15:0]) & dat_reg[31:16]) == 16'h0000;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (cmd_go) state_next = ST_ADDR;
			ST_ADDR: begin
				if (cmd_stb) state_next = cmd_go ? ST_ADDR : ST_IDLE;
				else if (addr_stb && aidx_reg == addr_total - 3'h1) state_next = ST_CHK;
			end
			ST_CHK: state_next = (row_hit && col_hit) ? ST_DATA : ST_IDLE;
			ST_DATA: begin
				if (cmd_stb) state_next = cmd_go ? ST_ADDR : ST_IDLE;
				else if (data_stb) state_next = data_hit ? ST_HIT : ST_IDLE;
			end
			ST_HIT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			aidx_reg <= 3'h0;
			col_acc_reg <= 16'h0000;
			row_acc_reg <= 32'h00000000;
		end else begin
			state_reg <= ctrl_reg[`NBTM_CTRL_EN] ? state_next : ST_IDLE;
			if (cmd_go) begin
				aidx_reg <= 3'h0;
				col_acc_reg <= 16'h0000;
				row_acc_reg <= 32'h00000000;
			end else if (state_reg == ST_ADDR && addr_stb) begin
				aidx_reg <= aidx_reg + 3'h1;
				if (aidx_reg < ncol) col_acc_reg[{aidx_reg[0], 3'h0} +: 8] <= cmd_byte;
				else row_acc_reg[{ridx[1:0], 3'h0} +: 8] <= cmd_byte;
			end
		end
	end
	// ---------------------------------------------------------------
	// Busy checks and trigger
	// ---------------------------------------------------------------
	for (genvar t = 0; t < 6; t++) begin : g_busy
		nbtm_busy_timer #(
			.MAX_CYC(BUSY_MAX_CYC)
		) u_timer (
			.pclk(pclk),
			.presetn(presetn),
			.enable(ctrl_reg[`NBTM_CTRL_BCHK] & ctrl_reg[`NBTM_CTRL_EN]),
			.cmd_stb(cmd_stb),
			.cmd_byte(cmd_byte),
			.busy(busy),
			.cmds(bcmd_reg[t]),
			.cfg(bcfg_reg[t]),
			.fire(fire[t])
		);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_out <= 1'b0;
			bfl_reg <= 6'h00;
			last_cmd_reg <= 8'h00;
			last_dat_reg <= 16'h0000;
		end else begin
			trig_out <= (state_reg == ST_HIT) | (|fire) | (trig_out & ~clr);
			bfl_reg <= fire | (bfl_reg & {6{~clr}});
			if (cmd_stb) last_cmd_reg <= cmd_byte;
			if (data_stb) last_dat_reg <= d_bus;
		end
	end
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_width_x8: assert property (!ctrl_reg[`NBTM_CTRL_X16] |-> d_bus[15:8] == 8'h00)
		else $error("upper data lines used in 8-bit mode");
	chk_quick_map: assert property (ctrl_reg[`NBTM_CTRL_QUICK] && lsb_reg < 5'd22
		|-> d_map[1] == ch_s[lsb_reg + 5'd1])
		else $error("quick setup line 1 not next channel");
	chk_user_map: assert property (!ctrl_reg[`NBTM_CTRL_QUICK] && map_reg[3] < 5'd24
		|-> d_map[3] == ch_s[map_reg[3]])
		else $error("user mapped line 3 wrong");
	chk_sdr_no_dqs: assert property (!ctrl_ddr && (pin_s[6] ^ pin_p[6])
		&& !(pin_p[3] && !pin_s[3]) |-> !rd_start)
		else $error("data strobe started a read in single-rate mode");
	chk_ddr_variant: assert property (ctrl_ddr && ctrl_reg[`NBTM_CTRL_START] && cmd_stb
		|-> $past(pin_s[2]) && !pin_s[2])
		else $error("variant command not on falling write strobe");
	chk_read_delay: assert property (dly_run_reg && rd_now && !rd_start
		|-> since_reg + 5'h01 == {1'b0, dly_reg})
		else $error("read sample not at programmed delay");
	chk_busy_cmd: assert property (cmd_stb && busy && !ctrl_reg[`NBTM_CTRL_BCMD]
		|-> !cmd_go)
		else $error("command accepted during busy while disabled");
	chk_busy_list: assert property (cmd_stb && busy && cmd_hit && busy_ok
		&& state_reg == ST_IDLE && ctrl_reg[`NBTM_CTRL_EN] |=> state_reg == ST_ADDR)
		else $error("listed command during busy not matched");
	chk_addr_len: assert property (state_reg == ST_ADDR && state_next == ST_CHK
		|-> aidx_reg + 3'h1 == addr_total)
		else $error("address length wrong");
	chk_dont_care: assert property (cmd_stb && cmd_reg[15:8] == 8'h00 |-> cmd_hit)
		else $error("don't-care command did not match");
	chk_cmd_class: assert property (we_rise && pin_s[0] && !ctrl_ddr |-> cmd_stb && !wdat_stb)
		else $error("command cycle misclassified");
	chk_addr_order: assert property (state_reg == ST_ADDR && addr_stb && aidx_reg == 3'h0
		&& ctrl_reg[`NBTM_CTRL_COL] && !cmd_stb |=> col_acc_reg[7:0] == $past(cmd_byte))
		else $error("first address byte not column low byte");
	cov_hit: cover property (state_reg == ST_HIT);
	cov_ddr_read: cover property (rd_now && ctrl_ddr);
	cov_busy_fire: cover property (|fire);
	cov_row_only: cover property (state_reg == ST_CHK && !ctrl_reg[`NBTM_CTRL_COL]);
endmodule
